// [logic/acq_command_handler.sv]
// acq_command_handler: acquisition, home, label and dac offset commands
// assumes an upstream parser hands over one decoded command at a time
// and that nv storage answers a read one cycle after nvRe
import acq_cmd_pkg::*;

module acq_command_handler
   import acq_cmd_pkg::*;
#(
   parameter int SERVO_CYC = SERVO_CYCLES
)(
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   // decoded command
   input  wire logic                          cmdValid,
   output logic                               cmdReady,
   input  wire logic [3:0]                    cmdOp,
   input  wire logic                          axisGiven,
   input  wire logic [7:0]                    axisNum,
   input  wire logic                          paramGiven,
   input  wire logic                          paramQuery,
   input  wire logic signed [31:0]            paramVal,
   input  wire logic                          pgmEntry,
   // acquisition setup fields
   input  wire logic [1:0]                    setupMode,
   input  wire logic [7:0]                    setupAxis,
   input  wire logic [2:0]                    setupChans,
   input  wire logic [9:0]                    setupRate,
   input  wire logic [9:0]                    setupCount,
   // axis status and trace data
   input  wire logic [NAXES-1:0]              axisSearching,
   input  wire logic [NAXES-1:0]              axisMoving,
   input  wire logic [NAXES-1:0]              axisAtSlew,
   input  wire logic [NTRACE-1:0][31:0]       traceData,
   // reply
   output logic                               rspValid,
   output logic [1:0]                         rspKind,
   output logic [31:0]                        rspData,
   output logic [7:0]                         rspErr,
   output logic [7:0]                         rspPrefix,
   // binary readout
   output logic                               byteValid,
   input  wire logic                          byteReady,
   output logic [7:0]                         byteData,
   output logic                               byteLast,
   // home preset and label marks
   output logic                               homeLoad,
   output logic [1:0]                         homeAxis,
   output logic [31:0]                        homePos,
   output logic                               labelMark,
   output logic [6:0]                         labelNum,
   // dac offsets and their nv store
   output logic [NCHAN-1:0][15:0]             dacOffset,
   output logic                               nvRe,
   output logic                               nvWe,
   output logic [2:0]                         nvAddr,
   output logic [15:0]                        nvWData,
   input  wire logic [15:0]                   nvRdData
);
   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_RESTA  = 7'h02,
      ST_RESTD  = 7'h04,
      ST_SAVE   = 7'h08,
      ST_RDADDR = 7'h10,
      ST_RDWAIT = 7'h20,
      ST_RDBYTE = 7'h40
   } state_e;

   typedef struct packed {
      state_e                  st;
      logic [2:0]              idx;
      logic                    armed;
      logic                    started;
      logic                    done;
      logic [1:0]              mode;
      logic [1:0]              trig;
      logic [2:0]              mask;
      logic [9:0]              rate;
      logic [9:0]              target;
      logic [9:0]              count;
      logic [9:0]              rateCnt;
      logic [15:0]             divCnt;
      logic [31:0]             tickCnt;
      logic                    capBusy;
      logic [1:0]              capIdx;
      logic [NTRACE:0][31:0]   snap;
      logic [MEM_AW-1:0]       wrAddr;
      logic [MEM_AW-1:0]       rdAddr;
      logic [31:0]             rdWord;
      logic [1:0]              byteIdx;
      logic                    rspValid;
      logic [1:0]              rspKind;
      logic [31:0]             rspData;
      logic [7:0]              rspErr;
      logic [7:0]              rspPrefix;
      logic                    homeLoad;
      logic [1:0]              homeAxis;
      logic [NAXES-1:0][31:0]  homeVal;
      logic                    labelMark;
      logic [6:0]              labelNum;
      logic [NCHAN-1:0][15:0]  dacPend;
      logic [NCHAN-1:0][15:0]  dacAct;
   } state_s;

   state_s q;
   state_s d;

   logic [31:0] memRdData;
   logic        memWe;
   logic        tick;
   logic        trigOk;
   logic        lastWord;

   // sample store
   acq_sample_mem u_mem (
      .mclk   (mclk),
      .wrEn   (memWe),
      .wrAddr (q.wrAddr),
      .wrData (q.snap[q.capIdx]),
      .rdAddr (q.rdAddr),
      .rdData (memRdData)
   );

   // tick word always stored, trace words only when selected
   assign memWe    = q.capBusy &&
                     (q.capIdx == 2'h0 || q.mask[2'(q.capIdx - 2'h1)]);
   assign tick     = q.divCnt == 16'(SERVO_CYC - 1);
   assign lastWord = (q.rdAddr + 1'b1) == q.wrAddr;

   // handshakes and outputs straight from the state
   assign cmdReady  = q.st == ST_IDLE;
   assign byteValid = q.st == ST_RDBYTE;
   assign byteData  = q.rdWord[31:24];
   assign byteLast  = byteValid && q.byteIdx == 2'h3 && lastWord;
   assign rspValid  = q.rspValid;
   assign rspKind   = q.rspKind;
   assign rspData   = q.rspData;
   assign rspErr    = q.rspErr;
   assign rspPrefix = q.rspPrefix;
   assign homeLoad  = q.homeLoad;
   assign homeAxis  = q.homeAxis;
   assign homePos   = q.homeVal[q.homeAxis];
   assign labelMark = q.labelMark;
   assign labelNum  = q.labelNum;
   assign dacOffset = q.dacAct;
   assign nvRe      = q.st == ST_RESTA;
   assign nvWe      = q.st == ST_SAVE;
   assign nvAddr    = q.idx;
   assign nvWData   = q.dacPend[q.idx];

   // trigger condition of the configured start mode
   always_comb begin
      case (q.mode)
         2'h0:    trigOk = 1'b1;
         2'h1:    trigOk = axisMoving[q.trig];
         2'h2:    trigOk = axisAtSlew[q.trig];
         default: trigOk = 1'b0;
      endcase
   end

   // next state: servo timing, capture, command decode, sequences
   always_comb begin
      logic [1:0] ax;
      logic [2:0] ch;
      logic       axOk;
      logic       chOk;
      logic [7:0] errCode;
      logic [7:0] errPfx;
      ax      = 2'(axisNum - 8'h01);
      ch      = 3'(axisNum - 8'h01);
      axOk    = axisNum != 8'h00 && axisNum <= AXIS_MAX;
      chOk    = axisNum != 8'h00 && axisNum <= CHAN_MAX;
      errCode = ERR_NONE;
      errPfx  = 8'h00;
      d           = q;
      d.rspValid  = 1'b0;
      d.homeLoad  = 1'b0;
      d.labelMark = 1'b0;

      // servo tick divider and tick count that tags samples
      d.divCnt = tick ? 16'h0000 : q.divCnt + 16'h0001;
      if (tick) begin
         d.tickCnt = q.tickCnt + 32'h0000_0001;
      end

      // armed request starts once its trigger condition holds
      if (q.armed && !q.done && !q.started && trigOk) begin
         d.started = 1'b1;
      end

      // one sample every rate+1 ticks; snapshot holds tick and traces
      if (tick && q.started && !q.done && !q.capBusy) begin
         if (q.rateCnt == 10'h000) begin
            d.capBusy = 1'b1;
            d.capIdx  = 2'h0;
            d.snap    = {traceData, q.tickCnt};
            d.rateCnt = q.rate;
         end else begin
            d.rateCnt = q.rateCnt - 10'h001;
         end
      end

      // write out the snapshot word by word
      if (q.capBusy) begin
         if (memWe) begin
            d.wrAddr = q.wrAddr + 1'b1;
         end
         d.capIdx = q.capIdx + 2'h1;
         if (q.capIdx == 2'h3) begin
            d.capBusy = 1'b0;
            d.count   = q.count + 10'h001;
            if (q.count + 10'h001 == q.target) begin
               d.done    = 1'b1;
               d.started = 1'b0;
            end
         end
      end

      case (q.st)
         // fetch saved offsets one channel at a time after reset
         ST_RESTA: begin
            d.st = ST_RESTD;
         end
         ST_RESTD: begin
            d.dacPend[q.idx] = nvRdData;
            d.dacAct[q.idx]  = nvRdData;
            d.idx            = q.idx + 3'h1;
            d.st             = (q.idx == 3'(NCHAN - 1)) ? ST_IDLE
                                                        : ST_RESTA;
         end
         // write every channel's offset into nv storage
         ST_SAVE: begin
            d.idx = q.idx + 3'h1;
            if (q.idx == 3'(NCHAN - 1)) begin
               d.st = ST_IDLE;
            end
         end
         // readout: wait for registered memory data, then four bytes
         ST_RDADDR: begin
            d.st = ST_RDWAIT;
         end
         ST_RDWAIT: begin
            d.rdWord  = memRdData;
            d.byteIdx = 2'h0;
            d.st      = ST_RDBYTE;
         end
         ST_RDBYTE: begin
            if (byteReady) begin
               d.rdWord  = {q.rdWord[23:0], 8'h00};
               d.byteIdx = q.byteIdx + 2'h1;
               if (q.byteIdx == 2'h3) begin
                  d.rdAddr = q.rdAddr + 1'b1;
                  d.st     = lastWord ? ST_IDLE : ST_RDADDR;
               end
            end
         end
         ST_IDLE: begin
            if (cmdValid) begin
               d.rspValid  = 1'b1;
               d.rspKind   = RSP_ACK;
               d.rspData   = 32'h0000_0000;
               d.rspErr    = ERR_NONE;
               d.rspPrefix = 8'h00;
               case (cmdOp)
                  // new setup throws away any earlier samples
                  OP_SETUP: begin
                     if (setupMode > MODE_MAX || setupAxis == 8'h00 ||
                         setupAxis > AXIS_MAX || setupRate > SAMPLE_MAX ||
                         setupCount == 10'h000 ||
                         setupCount > SAMPLE_MAX) begin
                        errCode = ERR_RANGE;
                     end else begin
                        d.mode    = setupMode;
                        d.trig    = 2'(setupAxis - 8'h01);
                        d.mask    = setupChans;
                        d.rate    = setupRate;
                        d.target  = setupCount;
                        d.count   = 10'h000;
                        d.wrAddr  = '0;
                        d.rateCnt = 10'h000;
                        d.capBusy = 1'b0;
                        d.done    = 1'b0;
                        d.started = 1'b0;
                        d.armed   = 1'b0;
                     end
                  end
                  OP_ENABLE: begin
                     if (!paramGiven) begin
                        errCode = ERR_PARAM_MISS;
                     end else if (|axisSearching) begin
                        errCode = ERR_ACQ_BUSY;
                     end else if (paramVal == 32'sh0000_0001) begin
                        d.armed = 1'b1;
                     end else if (paramVal == 32'sh0000_0000) begin
                        d.armed   = 1'b0;
                        d.started = 1'b0;
                     end else begin
                        errCode = ERR_RANGE;
                     end
                  end
                  OP_DONE_Q: begin
                     d.rspKind = RSP_VALUE;
                     d.rspData = {31'h0000_0000, q.done};
                  end
                  OP_COUNT_Q: begin
                     d.rspKind = RSP_VALUE;
                     d.rspData = {22'h00_0000, q.count};
                  end
                  // nothing to send until a full acquisition exists
                  OP_READOUT: begin
                     if (q.done) begin
                        d.rspValid = 1'b0;
                        d.rdAddr   = '0;
                        d.st       = ST_RDADDR;
                     end else begin
                        d.rspKind = RSP_EMPTY;
                     end
                  end
                  OP_HOME: begin
                     if (!axisGiven) begin
                        errCode = ERR_AXIS_MISS;
                     end else if (!axOk) begin
                        errCode = ERR_AXIS_RANGE;
                     end else if (paramQuery) begin
                        d.rspKind = RSP_VALUE;
                        d.rspData = q.homeVal[ax];
                     end else if (!paramGiven) begin
                        errCode = ERR_PARAM_MISS;
                     end else if (paramVal > HOME_LIM ||
                                  paramVal < -HOME_LIM) begin
                        errCode = ERR_PFX_RANGE;
                        errPfx  = axisNum;
                     end else begin
                        d.homeVal[ax] = paramVal;
                        d.homeAxis    = ax;
                        d.homeLoad    = 1'b1;
                     end
                  end
                  // harmless outside program entry, so no error there
                  OP_LABEL: begin
                     if (!pgmEntry) begin
                        d.rspKind = RSP_ACK;
                     end else if (!axisGiven) begin
                        errCode = ERR_PARAM_MISS;
                     end else if (axisNum == 8'h00 ||
                                  axisNum > LABEL_MAX) begin
                        errCode = ERR_PFX_RANGE;
                        errPfx  = axisNum;
                     end else begin
                        d.labelNum  = 7'(axisNum);
                        d.labelMark = 1'b1;
                     end
                  end
                  OP_DAC_OFS: begin
                     if (!axisGiven) begin
                        errCode = ERR_AXIS_MISS;
                     end else if (!chOk) begin
                        errCode = ERR_AXIS_RANGE;
                     end else if (paramQuery) begin
                        d.rspKind = RSP_VALUE;
                        d.rspData = 32'($signed(q.dacPend[ch]));
                     end else if (!paramGiven) begin
                        errCode = ERR_PARAM_MISS;
                     end else if (paramVal > DAC_LIM ||
                                  paramVal < -DAC_LIM) begin
                        errCode = ERR_DAC_MAX;
                        errPfx  = axisNum;
                     end else begin
                        d.dacPend[ch] = paramVal[15:0];
                     end
                  end
                  // pending offsets of the axis's channel pair go live
                  OP_FILT_UP: begin
                     if (!axisGiven) begin
                        errCode = ERR_AXIS_MISS;
                     end else if (!axOk) begin
                        errCode = ERR_AXIS_RANGE;
                     end else begin
                        d.dacAct[{ax, 1'b0}] = q.dacPend[{ax, 1'b0}];
                        d.dacAct[{ax, 1'b1}] = q.dacPend[{ax, 1'b1}];
                     end
                  end
                  OP_SAVE: begin
                     d.idx = 3'h0;
                     d.st  = ST_SAVE;
                  end
                  default: begin
                     errCode = ERR_RANGE;
                  end
               endcase
               if (errCode != ERR_NONE) begin
                  d.rspKind   = RSP_ERROR;
                  d.rspErr    = errCode;
                  d.rspPrefix = errPfx;
               end
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
   end

   // all state in one register; restore of offsets starts at reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q    <= '0;
         q.st <= ST_RESTA;
      end else begin
         q <= d;
      end
   end
endmodule : acq_command_handler

// [logic/acq_cmd_pkg.sv]
// acq_cmd_pkg: constants shared by the acquisition command handler
// assumes commands arrive already parsed into opcode and number fields
package acq_cmd_pkg;
   // machine size
   localparam int NAXES  = 4;
   localparam int NCHAN  = 2 * NAXES;   // two dac channels per axis
   localparam int NTRACE = 3;           // trace channels per sample
   localparam int MEM_AW = 12;          // sample store address bits

   // timing: servo cycle at the 10 ns clock
   localparam int CLK_PERIOD_NS   = 10;
   localparam int SERVO_PERIOD_US = 400;
   localparam int SERVO_CYCLES    = SERVO_PERIOD_US * 1000 / CLK_PERIOD_NS;

   // command opcodes
   localparam logic [3:0] OP_SETUP   = 4'h0;
   localparam logic [3:0] OP_ENABLE  = 4'h1;
   localparam logic [3:0] OP_DONE_Q  = 4'h2;
   localparam logic [3:0] OP_COUNT_Q = 4'h3;
   localparam logic [3:0] OP_READOUT = 4'h4;
   localparam logic [3:0] OP_HOME    = 4'h5;
   localparam logic [3:0] OP_LABEL   = 4'h6;
   localparam logic [3:0] OP_DAC_OFS = 4'h7;
   localparam logic [3:0] OP_FILT_UP = 4'h8;
   localparam logic [3:0] OP_SAVE    = 4'h9;

   // reply kinds
   localparam logic [1:0] RSP_ACK   = 2'h0;
   localparam logic [1:0] RSP_VALUE = 2'h1;
   localparam logic [1:0] RSP_ERROR = 2'h2;
   localparam logic [1:0] RSP_EMPTY = 2'h3;

   // error codes; prefixed ones carry a number in rspPrefix
   localparam logic [7:0] ERR_NONE       = 8'h00;
   localparam logic [7:0] ERR_AXIS_MISS  = 8'h25;   // 37
   localparam logic [7:0] ERR_AXIS_RANGE = 8'h09;
   localparam logic [7:0] ERR_PARAM_MISS = 8'h26;   // 38
   localparam logic [7:0] ERR_RANGE      = 8'h07;
   localparam logic [7:0] ERR_PFX_RANGE  = 8'h02;   // xx2
   localparam logic [7:0] ERR_DAC_MAX    = 8'h10;   // xx16
   localparam logic [7:0] ERR_ACQ_BUSY   = 8'h0F;

   // value limits
   localparam logic [7:0]         AXIS_MAX   = 8'h04;
   localparam logic [7:0]         CHAN_MAX   = 8'h08;
   localparam logic [7:0]         LABEL_MAX  = 8'h64;   // 100
   localparam logic [9:0]         SAMPLE_MAX = 10'h3E8; // 1000
   localparam logic [1:0]         MODE_MAX   = 2'h2;
   localparam logic signed [31:0] HOME_LIM   = 32'sh7735_9400; // 2e9
   localparam logic signed [31:0] DAC_LIM    = 32'sh0000_2710; // 10000 mV
endpackage : acq_cmd_pkg

// [logic/acq_sample_mem.sv]
// acq_sample_mem: one write port, one read port sample store
// assumes a single clock; read data is registered, one cycle late
module acq_sample_mem
   import acq_cmd_pkg::*;
(
   // clock
   input  wire logic              mclk,
   // write side
   input  wire logic              wrEn,
   input  wire logic [MEM_AW-1:0] wrAddr,
   input  wire logic [31:0]       wrData,
   // read side
   input  wire logic [MEM_AW-1:0] rdAddr,
   output logic      [31:0]       rdData
);
   logic [31:0] store [2**MEM_AW];

   // no reset: contents are only read after a completed acquisition
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         store[wrAddr] <= wrData;
      end
      rdData <= store[rdAddr];
   end
endmodule : acq_sample_mem

// [dv/nv_store_model.sv]
// nv store model: eight saved offset words for the handler
// assumes the handler takes read data the cycle after nvRe
module nv_store_model (
   input  wire logic        mclk, nvRe, nvWe,
   input  wire logic [2:0]  nvAddr,
   input  wire logic [15:0] nvWData,
   output logic      [15:0] nvRdData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [8];
   // distinct words so a misplaced restore shows
   initial begin
      foreach (mem[k]) mem[k] = 16'h0100 + 16'(k);
   end
   // words survive reset; an idle read line toggles, never holds
   always @(posedge mclk) begin
      if (nvWe) mem[nvAddr] <= nvWData;
      nvRdData <= nvRe ? mem[nvAddr] : ~nvRdData;
   end
endmodule : nv_store_model

// [dv/acq_command_handler_assertions.sv]
// checker: reply, offset and byte relations of the command handler
// assumes one mclk domain; bound into every handler instance
module acq_cmd_checker
   import acq_cmd_pkg::*;
(
   input wire logic mclk, rst_n, cmdValid, cmdReady, axisGiven, paramGiven,
   input wire logic paramQuery, pgmEntry, rspValid, byteValid, byteReady,
   input wire logic homeLoad, labelMark,
   input wire logic [3:0] cmdOp,
   input wire logic [7:0] axisNum, rspErr, rspPrefix, byteData,
   input wire logic signed [31:0] paramVal,
   input wire logic [NAXES-1:0] axisSearching,
   input wire logic [1:0] rspKind, homeAxis,
   input wire logic [31:0] rspData, homePos,
   input wire logic [NCHAN-1:0][15:0] dacOffset
);
   timeunit 1ns;
   timeprecision 1ns;
   // taken command and its decoded kinds
   wire logic tk = cmdValid && cmdReady;
   wire logic fu = tk && cmdOp == OP_FILT_UP;
   wire logic setv = tk && axisGiven && paramGiven && !paramQuery;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_done; tk && cmdOp == OP_DONE_Q |=> rspValid && rspData <= 1;
   endproperty
   a_done: assert property (p_done) else $error("done reply");
   property p_busy; tk && cmdOp == OP_ENABLE && |axisSearching
      |=> rspKind == RSP_ERROR && rspErr == ERR_ACQ_BUSY; endproperty
   a_busy: assert property (p_busy) else $error("enable busy");
   property p_noax; tk && cmdOp == OP_HOME && !axisGiven
      |=> rspValid && rspErr == ERR_AXIS_MISS; endproperty
   a_noax: assert property (p_noax) else $error("axis missing");
   property p_dmax; setv && cmdOp == OP_DAC_OFS && paramVal > DAC_LIM
      && axisNum inside {[1:8]} |=> rspErr == ERR_DAC_MAX
      && rspPrefix == $past(axisNum); endproperty
   a_dmax: assert property (p_dmax) else $error("dac range");
   // restore writes happen while cmdReady is low, so they are exempt
   property p_hold; $changed(dacOffset) && $past(cmdReady) |-> $past(fu);
   endproperty
   a_hold: assert property (p_hold) else $error("offset early");
   property p_lbl; tk && cmdOp == OP_LABEL && !pgmEntry
      |=> !labelMark && rspKind == RSP_ACK; endproperty
   a_lbl: assert property (p_lbl) else $error("label outside");
   property p_home; setv && cmdOp == OP_HOME && axisNum inside {[1:4]}
      && paramVal <= HOME_LIM && paramVal >= -HOME_LIM |=> homeLoad
      && homePos == $past(paramVal) && homeAxis == 2'($past(axisNum) - 1);
   endproperty
   a_home: assert property (p_home) else $error("home preset");
   property p_byte; byteValid && !byteReady |=> byteValid && $stable(byteData);
   endproperty
   a_byte: assert property (p_byte) else $error("byte hold");
   c_read: cover property (byteValid && byteReady);
   c_fu: cover property (fu);
   c_home: cover property (homeLoad);
endmodule : acq_cmd_checker

bind acq_command_handler acq_cmd_checker u_chk (.*);

// [dv/tb_top.sv]
// tb_top: directed command scenarios for the acquisition handler
// assumes the nv store model on the nv port; servo tick cut to 20
module tb_top
   import acq_cmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rst_n = 0, cmdValid = 0, axisGiven = 1, paramGiven = 1;
   logic paramQuery = 0, pgmEntry = 0, byteReady = 0, cmdReady, rspValid;
   logic byteValid, byteLast, homeLoad, labelMark, nvRe, nvWe;
   logic [1:0] rspKind, homeAxis, setupMode = 2'h0;
   logic [2:0] nvAddr, setupChans = 3'h1;
   logic [3:0] cmdOp = 4'h0;
   logic [6:0] labelNum;
   logic [7:0] axisNum = 8'h00, rspErr, rspPrefix, byteData, setupAxis = 8'h01;
   logic [9:0] setupRate = 10'h000, setupCount = 10'h002;
   logic [15:0] nvWData, nvRdData;
   logic [31:0] rspData, homePos, w0, w1;
   logic signed [31:0] paramVal = 0;
   logic [NAXES-1:0] axisSearching = 4'h0, axisMoving = 4'h0;
   logic [NTRACE-1:0][31:0] traceData = {3{32'h1234_5678}};
   logic [NCHAN-1:0][15:0] dacOffset;
   int n_mismatch = 0, n_checks = 0, cyc = 0, n;
   acq_command_handler #(.SERVO_CYC(20)) uut (.*, .axisAtSlew(4'h0));
   nv_store_model u_nv (.*);
   // clock, and a hang guard far above the few hundred cycles used
   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         conclude();
      end
   end
   task chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // hold a command until the edge that takes it, then release
   task go(input logic [3:0] op, input logic [7:0] an, input int pv);
      int w;
      cmdOp    = op;
      axisNum  = an;
      paramVal = pv;
      cmdValid = 1;
      // ready judged settled, off the edge; the next edge takes it
      for (w = 0; w < 100 && cmdReady !== 1; w++) @(posedge mclk) #1;
      @(posedge mclk);
      #1 cmdValid = 0;
   endtask : go
   // reply stands the cycle after the take; errors as prefix, code
   task ans(input logic [1:0] k, input logic [31:0] v);
      chk(rspValid, 1);
      chk(rspKind, k);
      if (k == RSP_VALUE) chk(rspData, v);
      if (k == RSP_ERROR) chk({rspPrefix, rspErr}, v);
      @(posedge mclk);
      #1;
   endtask : ans
   task reset();
      rst_n = 0;
      repeat (2) @(posedge mclk);
      #1 rst_n = 1;
      repeat (17) @(posedge mclk);
      #1;
   endtask : reset
   task t_dac();
      chk(dacOffset[2], 16'h0102);
      go(OP_DAC_OFS, 8'h03, 500); ans(RSP_ACK, 0);
      chk(dacOffset[2], 16'h0102);
      paramQuery = 1; go(OP_DAC_OFS, 8'h03, 0); paramQuery = 0;
      ans(RSP_VALUE, 500);
      go(OP_FILT_UP, 8'h02, 0); ans(RSP_ACK, 0);
      chk({dacOffset[3], dacOffset[2]}, 32'h0103_01F4);
      go(OP_DAC_OFS, 8'h04, 10001); ans(RSP_ERROR, 32'h0000_0410);
      go(OP_SAVE, 8'h00, 0); ans(RSP_ACK, 0);
      for (n = 0; n < 20 && cmdReady !== 1; n++) @(posedge mclk) #1;
      reset();
      chk(dacOffset[2], 16'h01F4);
      $display("dac offset test done");
   endtask : t_dac
   task t_misc();
      go(OP_HOME, 8'h05, 7); ans(RSP_ERROR, 32'h0000_0009);
      axisGiven = 0; go(OP_HOME, 8'h00, 7); axisGiven = 1;
      ans(RSP_ERROR, 32'h0000_0025);
      paramGiven = 0; go(OP_HOME, 8'h02, 7); paramGiven = 1;
      ans(RSP_ERROR, 32'h0000_0026);
      go(OP_HOME, 8'h04, -2000000000);
      chk(homePos, 32'h88CA_6C00);
      ans(RSP_ACK, 0);
      go(OP_LABEL, 8'h64, 0); chk(labelMark, 0); ans(RSP_ACK, 0);
      pgmEntry = 1; go(OP_LABEL, 8'h64, 0);
      chk({labelMark, labelNum}, 8'hE4);
      ans(RSP_ACK, 0); pgmEntry = 0;
      $display("home and label test done");
   endtask : t_misc
   task t_acq();
      go(OP_READOUT, 8'h00, 0); ans(RSP_EMPTY, 0);
      go(OP_SETUP, 8'h00, 0); ans(RSP_ACK, 0);
      axisSearching = 4'h2; go(OP_ENABLE, 8'h00, 1); axisSearching = 4'h0;
      ans(RSP_ERROR, 32'h0000_000F);
      go(OP_ENABLE, 8'h00, 1); ans(RSP_ACK, 0);
      n = 0;
      do begin
         go(OP_DONE_Q, 8'h00, 0); w0 = rspData; n++;
         ans(RSP_VALUE, {31'h0000_0000, w0[0]});
      end while (w0 !== 1 && n < 40);
      chk(w0, 1);
      go(OP_COUNT_Q, 8'h00, 0); ans(RSP_VALUE, 2);
      go(OP_ENABLE, 8'h00, 0); ans(RSP_ACK, 0);
      go(OP_READOUT, 8'h00, 0);
      n = 0;
      // a byte counts when valid and ready stand settled before its edge
      for (int i = 0; i < 300 && n < 16; i++) begin
         if (byteValid && byteReady) begin
            w1 = {w1[23:0], byteData};
            n++;
            if (n == 4) w0 = w1;
            if (n == 8) chk(w1, 32'h1234_5678);
            if (n == 12) chk(w1 - w0, 1);
            if (n == 16) chk(byteLast, 1);
         end
         @(posedge mclk);
         #1 byteReady = ~byteReady;
      end
      chk(n, 16);
      chk(byteValid, 0);
      $display("acquisition test done");
   endtask : t_acq
   // start on motion: nothing collected until the trigger axis moves
   task t_trig();
      setupMode = 2'h1;
      go(OP_SETUP, 8'h00, 0); ans(RSP_ACK, 0);
      go(OP_ENABLE, 8'h00, 1); ans(RSP_ACK, 0);
      repeat (60) @(posedge mclk);
      #1;
      go(OP_COUNT_Q, 8'h00, 0); ans(RSP_VALUE, 0);
      axisMoving = 4'h1;
      repeat (60) @(posedge mclk);
      #1;
      go(OP_DONE_Q, 8'h00, 0); ans(RSP_VALUE, 1);
      $display("trigger test done");
   endtask : t_trig
   initial begin
      reset();
      t_dac();
      t_misc();
      t_acq();
      t_trig();
      conclude();
   end
endmodule : tb_top
